// >>> psfr_pkg.sv
// shared constants and types for the power stage fault reporting block
package psfr_pkg;
	// half-bridge count and channel indices
	localparam int NUM_HB = 4;
	localparam int HB_A = 0;
	localparam int HB_B = 1;
	localparam int HB_C = 2;
	localparam int HB_D = 3;
	// output configuration encodings on the mode input
	localparam logic [1:0] MODE_BRIDGE_TIED = 2'h0;
	localparam logic [1:0] MODE_PARALLEL_BRIDGE = 2'h1;
	localparam logic [1:0] MODE_SINGLE_ENDED = 2'h2;
	// group masks per half-bridge set
	localparam logic [3:0] GRP_AB = 4'h3;
	localparam logic [3:0] GRP_CD = 4'hC;
	localparam logic [3:0] GRP_ALL = 4'hF;
	localparam logic [3:0] GRP_NONE = 4'h0;
	// reset values of the status flags (released, high)
	localparam logic FLAG_RELEASED = 1'h1;
	// clock rate and fault-to-reset spacing the controller must keep
	localparam int CLK_MHZ = 100;
	localparam int RESET_HOLDOFF_MS = 4;
	localparam int RESET_HOLDOFF_CYC = RESET_HOLDOFF_MS * 1000 * CLK_MHZ;
	// top-level state
	typedef enum logic [1:0] {PSFR_POWERUP, PSFR_RUN, PSFR_LATCHED} psfr_state_e;
endpackage

// >>> psfr_fault_if.sv
// fault bus carried between the top and the grouping unit
`timescale 1ns/1ps
interface psfr_fault_if;
	logic [3:0] chanErr;
	logic [3:0] bootUv;
	logic [1:0] mode;
	logic [3:0] hbOff;
	modport src (output chanErr, output bootUv, output mode, input hbOff);
	modport grp (input chanErr, input bootUv, input mode, output hbOff);
endinterface

// >>> psfr_sync.sv
// two-flop synchroniser for a bundle of asynchronous fault inputs
`timescale 1ns/1ps
module psfr_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_r;
	logic [W-1:0] sync_nxt;

	// only the second stage is ever read outside
	always_comb begin
		meta_nxt = din;
		sync_nxt = meta_r;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign dout = sync_r;
endmodule

// >>> psfr_group.sv
// maps per-channel errors onto half-bridge shutdown groups
`timescale 1ns/1ps
module psfr_group (
	// fault bus
	psfr_fault_if.grp fb
);
	logic [3:0] grpOff;

	always_comb begin
		grpOff = psfr_pkg::GRP_NONE;
		if (fb.mode == psfr_pkg::MODE_PARALLEL_BRIDGE) begin
			if (|fb.chanErr) begin
				grpOff = psfr_pkg::GRP_ALL;
			end
		end else begin
			if (|(fb.chanErr & psfr_pkg::GRP_AB)) begin
				grpOff = grpOff | psfr_pkg::GRP_AB;
			end
			if (|(fb.chanErr & psfr_pkg::GRP_CD)) begin
				grpOff = grpOff | psfr_pkg::GRP_CD;
			end
		end
	end

	assign fb.hbOff = grpOff | fb.bootUv;
endmodule

// >>> psfr_top.sv
// fault handling and status flag logic of a four half-bridge power stage
// How it works
// - any fault that shuts the stage down pulls the shutdown flag low.
// - high warning flags go low while temperature is above 125 C.
// - low warning flag goes low while temperature is above 100 C.
// - all flags high is normal; warning alone keeps shutdown high.
// - flags are active-low open-drain outputs toward the controller.
// - reset low forces the shutdown flag high whatever faults exist.
// - a fault puts affected outputs in high impedance; all but bootstrap undervoltage lower shutdown.
// - undervoltage and bootstrap undervoltage recover by themselves once removed.
// - channel errors turn off A+B or C+D, or all in parallel mode.
// - bootstrap undervoltage turns off only its own half-bridge.
// - outputs stay off until gate-drive and common supplies are good.
// - reset low enables weak pulldowns to charge bootstrap capacitors, except in single-ended mode.
// - overtemperature error latches until reset is asserted.
// - overload recovers only on a rising edge of reset.
// - reset low forces all four half-bridges into high impedance.
`timescale 1ns/1ps
module psfr_top (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// device reset pin, active low, from the controller
	input wire logic devResetN,
	// output configuration
	input wire logic bridgeTiedMode,
	input wire logic parallelBridgeMode,
	input wire logic singleEndedMode,
	// fault detections
	input wire logic overtempError,
	input wire logic tempAbove100,
	input wire logic tempAbove125,
	input wire logic [3:0] overloadProtect,
	input wire logic undervoltageProtect,
	input wire logic gateDriveSupplyOk,
	input wire logic commonSupplyOk,
	input wire logic [3:0] bootUndervoltage,
	// half-bridge control
	output logic [3:0] hbHiZ,
	output logic [3:0] hbPulldown,
	// open-drain flags: level, output enable
	output logic shutdownFlagN,
	output logic shutdownFlagOe,
	output logic tempWarningN,
	output logic tempWarningOe,
	output logic tempWarningLowN,
	output logic tempWarningLowOe,
	output logic tempWarningHighN,
	output logic tempWarningHighOe,
	// controller may release reset once this is high
	output logic resetReleaseOk
);
	localparam int SW = 16;
	logic [SW-1:0] syncIn;
	logic [SW-1:0] syncOut;
	logic rstPin;
	logic modePbtl;
	logic modeSe;
	logic oteS;
	logic w100S;
	logic w125S;
	logic [3:0] olS;
	logic uvS;
	logic gOk;
	logic cOk;
	logic [3:0] bootS;
	logic [1:0] modeEnc;

	// every pin passes two flops before use
	// detections sampled on block clock
	assign syncIn = {devResetN, parallelBridgeMode, singleEndedMode, overtempError,
		tempAbove100, tempAbove125, overloadProtect, undervoltageProtect,
		gateDriveSupplyOk, commonSupplyOk, bootUndervoltage[3:1]};
	psfr_sync #(.W(SW)) uSync (
		.core_clk(core_clk),
		.rstn(rstn),
		.din(syncIn),
		.dout(syncOut)
	);
	logic bootS0;
	psfr_sync #(.W(1)) uSyncB0 (
		.core_clk(core_clk),
		.rstn(rstn),
		.din(bootUndervoltage[0]),
		.dout(bootS0)
	);
	assign rstPin = syncOut[15];
	assign modePbtl = syncOut[14];
	assign modeSe = syncOut[13];
	assign oteS = syncOut[12];
	assign w100S = syncOut[11];
	assign w125S = syncOut[10];
	assign olS = syncOut[9:6];
	assign uvS = syncOut[5];
	assign gOk = syncOut[4];
	assign cOk = syncOut[3];
	assign bootS = {syncOut[2:0], bootS0};

	// bridge-tied is the default when no other mode pin is set
	assign modeEnc = modePbtl ? psfr_pkg::MODE_PARALLEL_BRIDGE :
		(modeSe ? psfr_pkg::MODE_SINGLE_ENDED : psfr_pkg::MODE_BRIDGE_TIED);

	// latched and live fault state
	psfr_pkg::psfr_state_e state_r;
	psfr_pkg::psfr_state_e state_nxt;
	logic oteLatch_r;
	logic oteLatch_nxt;
	logic [3:0] olLatch_r;
	logic [3:0] olLatch_nxt;
	logic rstPrev_r;
	logic rstPrev_nxt;
	logic supplyGood;
	logic rstRise;

	assign supplyGood = gOk & cOk & ~uvS;
	assign rstRise = rstPin & ~rstPrev_r;

	// latches: set wins, cleared only by reset pin
	always_comb begin
		rstPrev_nxt = rstPin;
		oteLatch_nxt = oteLatch_r;
		olLatch_nxt = olLatch_r;
		state_nxt = state_r;
		// overtemperature error clears while reset low
		if (!rstPin) begin
			oteLatch_nxt = 1'b0;
		end
		// overload cleared only on reset rising edge
		if (rstRise) begin
			olLatch_nxt = 4'h0;
		end
		if (oteS) begin
			oteLatch_nxt = 1'b1;
		end
		olLatch_nxt = olLatch_nxt | olS;
		case (state_r)
			psfr_pkg::PSFR_POWERUP: begin
				// wait for all supplies, any order
				if (supplyGood) begin
					state_nxt = psfr_pkg::PSFR_RUN;
				end
			end
			psfr_pkg::PSFR_RUN: begin
				if (oteS) begin
					state_nxt = psfr_pkg::PSFR_LATCHED;
				end
			end
			psfr_pkg::PSFR_LATCHED: begin
				if (!oteLatch_nxt) begin
					state_nxt = psfr_pkg::PSFR_RUN;
				end
			end
			default: begin
				state_nxt = psfr_pkg::PSFR_POWERUP;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= psfr_pkg::PSFR_POWERUP;
			oteLatch_r <= 1'b0;
			olLatch_r <= 4'h0;
			rstPrev_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			oteLatch_r <= oteLatch_nxt;
			olLatch_r <= olLatch_nxt;
			rstPrev_r <= rstPrev_nxt;
		end
	end

	// channel grouping through the fault bus
	psfr_fault_if fbus ();
	assign fbus.chanErr = olLatch_nxt;
	assign fbus.bootUv = bootS;
	assign fbus.mode = modeEnc;
	psfr_group uGroup (
		.fb(fbus.grp)
	);

	// registered outputs
	logic [3:0] hbHiZ_r;
	logic [3:0] hbHiZ_nxt;
	logic [3:0] pull_r;
	logic [3:0] pull_nxt;
	logic sdN_r;
	logic sdN_nxt;
	logic wLowN_r;
	logic wLowN_nxt;
	logic wHighN_r;
	logic wHighN_nxt;
	logic sdOe_r;
	logic wLowOe_r;
	logic wHighOe_r;
	logic globalOff;
	logic faultShut;

	// undervoltage state is live, recovers by itself
	assign globalOff = ~supplyGood | oteLatch_nxt | (state_r == psfr_pkg::PSFR_POWERUP);
	assign faultShut = globalOff | (|olLatch_nxt);

	always_comb begin
		hbHiZ_nxt = fbus.hbOff;
		pull_nxt = 4'h0;
		sdN_nxt = psfr_pkg::FLAG_RELEASED;
		// fault forces high impedance at once
		if (globalOff) begin
			hbHiZ_nxt = psfr_pkg::GRP_ALL;
		end
		if (faultShut) begin
			sdN_nxt = 1'b0;
		end
		if (!rstPin) begin
			hbHiZ_nxt = psfr_pkg::GRP_ALL;
			sdN_nxt = psfr_pkg::FLAG_RELEASED;
			// weak pulldown, not in single-ended mode
			pull_nxt = modeSe ? 4'h0 : psfr_pkg::GRP_ALL;
		end
		wLowN_nxt = ~w100S;
		wHighN_nxt = ~w125S;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hbHiZ_r <= psfr_pkg::GRP_ALL;
			pull_r <= 4'h0;
			sdN_r <= psfr_pkg::FLAG_RELEASED;
			wLowN_r <= psfr_pkg::FLAG_RELEASED;
			wHighN_r <= psfr_pkg::FLAG_RELEASED;
			sdOe_r <= ~psfr_pkg::FLAG_RELEASED;
			wLowOe_r <= ~psfr_pkg::FLAG_RELEASED;
			wHighOe_r <= ~psfr_pkg::FLAG_RELEASED;
		end else begin
			hbHiZ_r <= hbHiZ_nxt;
			pull_r <= pull_nxt;
			sdN_r <= sdN_nxt;
			wLowN_r <= wLowN_nxt;
			wHighN_r <= wHighN_nxt;
			sdOe_r <= ~sdN_nxt;
			wLowOe_r <= ~wLowN_nxt;
			wHighOe_r <= ~wHighN_nxt;
		end
	end

	// counts time since shutdown fell; limitation: advisory only
	logic [25:0] hold_r;
	logic [25:0] hold_nxt;
	logic relOk_r;
	logic relOk_nxt;
	always_comb begin
		hold_nxt = hold_r;
		relOk_nxt = relOk_r;
		if (sdN_r && !sdN_nxt) begin
			hold_nxt = 26'h0;
			relOk_nxt = 1'b0;
		end else if (hold_r < 26'(psfr_pkg::RESET_HOLDOFF_CYC)) begin
			hold_nxt = hold_r + 26'h1;
		end else begin
			relOk_nxt = 1'b1;
		end
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hold_r <= 26'h0;
			relOk_r <= 1'b0;
		end else begin
			hold_r <= hold_nxt;
			relOk_r <= relOk_nxt;
		end
	end

	// open-drain, enables kept in their own flops
	assign shutdownFlagN = sdN_r;
	assign shutdownFlagOe = sdOe_r;
	assign tempWarningN = wHighN_r;
	assign tempWarningOe = wHighOe_r;
	assign tempWarningLowN = wLowN_r;
	assign tempWarningLowOe = wLowOe_r;
	assign tempWarningHighN = wHighN_r;
	assign tempWarningHighOe = wHighOe_r;
	assign hbHiZ = hbHiZ_r;
	assign hbPulldown = pull_r;
	assign resetReleaseOk = relOk_r;

	// checks
	a_reset_sd_high: assert property (@(posedge core_clk) disable iff (!rstn)
		!rstPin |=> shutdownFlagN) else $error("shutdown flag low during reset");
	a_reset_all_hiz: assert property (@(posedge core_clk) disable iff (!rstn)
		!rstPin |=> hbHiZ == 4'hF) else $error("bridge active during reset");
	a_reset_pulldown: assert property (@(posedge core_clk) disable iff (!rstn)
		(!rstPin && !modeSe) |=> hbPulldown == 4'hF) else $error("pulldown missing in reset");
	a_uv_shuts_down: assert property (@(posedge core_clk) disable iff (!rstn)
		(rstPin && uvS) |=> (!shutdownFlagN && hbHiZ == 4'hF)) else $error("uv not shut");
	a_uv_recovers: assert property (@(posedge core_clk) disable iff (!rstn)
		(rstPin && supplyGood && !oteLatch_nxt && olLatch_nxt == 4'h0
		&& state_r == psfr_pkg::PSFR_RUN) |=> shutdownFlagN) else $error("no recovery");
	a_warn_low: assert property (@(posedge core_clk) disable iff (!rstn)
		w100S |=> !tempWarningLowN) else $error("low warning missing");
	a_warn_high: assert property (@(posedge core_clk) disable iff (!rstn)
		w125S |=> (!tempWarningHighN && !tempWarningN)) else $error("high warning missing");
	a_ote_latched: assert property (@(posedge core_clk) disable iff (!rstn)
		(oteLatch_r && rstPin) |=> oteLatch_r) else $error("ote latch lost");
	a_ol_latched: assert property (@(posedge core_clk) disable iff (!rstn)
		(olLatch_r != 4'h0 && !rstRise) |=> olLatch_r != 4'h0) else $error("ol lost");
	a_parallel_bridge_mode_all_off: assert property (@(posedge core_clk) disable iff (!rstn)
		(modePbtl && olS != 4'h0) |=> hbHiZ == 4'hF) else $error("parallel_bridge_mode group");
	a_boot_own_hb: assert property (@(posedge core_clk) disable iff (!rstn)
		(bootS == 4'h1 && globalOff == 1'b0 && olLatch_nxt == 4'h0 && rstPin)
		|=> (hbHiZ == 4'h1 && shutdownFlagN)) else $error("boot uv spread");
	a_pwrup_hiz: assert property (@(posedge core_clk) disable iff (!rstn)
		(state_r == psfr_pkg::PSFR_POWERUP) |=> hbHiZ == 4'hF) else $error("early on");
	a_od_enable: assert property (@(posedge core_clk) disable iff (!rstn)
		shutdownFlagOe == !shutdownFlagN) else $error("od enable wrong");
	c_ote_trip: cover property (@(posedge core_clk) disable iff (!rstn)
		state_r == psfr_pkg::PSFR_LATCHED);
	c_ol_clear: cover property (@(posedge core_clk) disable iff (!rstn)
		olLatch_r != 4'h0 ##1 rstRise);
	c_uv_recover: cover property (@(posedge core_clk) disable iff (!rstn)
		!shutdownFlagN ##1 shutdownFlagN);
endmodule

// >>> psfr_ctrl_model.sv
// behavioural controller that owns the device reset pin and reads the flag lines
`timescale 1ns/1ps
module psfr_ctrl_model (
	// clock
	input wire logic core_clk,
	// open-drain enables from the device
	input wire logic shutdownFlagOe,
	input wire logic tempWarningOe,
	input wire logic tempWarningLowOe,
	input wire logic tempWarningHighOe,
	// device reset pin and resolved lines {shutdown, low, high, single}
	output logic devResetN,
	output logic [3:0] flagLines,
	output logic coolRequest
);
	assign flagLines = ~{shutdownFlagOe, tempWarningLowOe, tempWarningHighOe, tempWarningOe};
	assign coolRequest = ~flagLines[0];
	// reset held low across supply ramps
	initial begin
		devResetN = 1'b0;
	end
	// drive the pin just after the falling edge
	task automatic hold_reset;
		@(negedge core_clk);
		devResetN = 1'b0;
	endtask
	task automatic release_reset;
		@(negedge core_clk);
		devResetN = 1'b1;
	endtask
	// early release on purpose: the 4 ms holdoff exceeds the run budget
	task automatic pulse_reset;
		hold_reset();
		repeat (4) @(negedge core_clk);
		release_reset();
	endtask
endmodule

// >>> power_stage_fault_reporting_test.sv
// self-checking bench for the power stage fault reporting block
`timescale 1ns/1ps
module power_stage_fault_reporting_test;
	logic core_clk;
	logic rstn;
	logic devResetN;
	logic bridgeTiedMode;
	logic parallelBridgeMode;
	logic singleEndedMode;
	logic overtempError;
	logic tempAbove100;
	logic tempAbove125;
	logic [3:0] overloadProtect;
	logic undervoltageProtect;
	logic gateDriveSupplyOk;
	logic commonSupplyOk;
	logic [3:0] bootUndervoltage;
	logic [3:0] hbHiZ;
	logic [3:0] hbPulldown;
	logic shutdownFlagN;
	logic shutdownFlagOe;
	logic tempWarningN;
	logic tempWarningOe;
	logic tempWarningLowN;
	logic tempWarningLowOe;
	logic tempWarningHighN;
	logic tempWarningHighOe;
	logic resetReleaseOk;
	logic [3:0] flagLines;
	int bad_count;
	int checks_done;
	int cycles;

	psfr_top u_dut (.core_clk(core_clk), .rstn(rstn), .devResetN(devResetN),
		.bridgeTiedMode(bridgeTiedMode), .parallelBridgeMode(parallelBridgeMode),
		.singleEndedMode(singleEndedMode), .overtempError(overtempError),
		.tempAbove100(tempAbove100), .tempAbove125(tempAbove125),
		.overloadProtect(overloadProtect), .undervoltageProtect(undervoltageProtect),
		.gateDriveSupplyOk(gateDriveSupplyOk), .commonSupplyOk(commonSupplyOk),
		.bootUndervoltage(bootUndervoltage), .hbHiZ(hbHiZ), .hbPulldown(hbPulldown),
		.shutdownFlagN(shutdownFlagN), .shutdownFlagOe(shutdownFlagOe),
		.tempWarningN(tempWarningN), .tempWarningOe(tempWarningOe),
		.tempWarningLowN(tempWarningLowN), .tempWarningLowOe(tempWarningLowOe),
		.tempWarningHighN(tempWarningHighN), .tempWarningHighOe(tempWarningHighOe),
		.resetReleaseOk(resetReleaseOk));

	psfr_ctrl_model u_ctrl (.core_clk(core_clk), .shutdownFlagOe(shutdownFlagOe),
		.tempWarningOe(tempWarningOe), .tempWarningLowOe(tempWarningLowOe),
		.tempWarningHighOe(tempWarningHighOe), .devResetN(devResetN),
		.flagLines(flagLines), .coolRequest());

	// free-running 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// verdict and end of run
	task automatic conclude;
		if (bad_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// one comparison, reported at once
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// two sync flops plus the output flop, with one edge spare
	task automatic settle;
		repeat (4) @(negedge core_clk);
	endtask

	// flag pins and the resolved lines must agree
	task automatic flags(input logic sd, input logic lo, input logic hi);
		chk({4'h0, shutdownFlagN, tempWarningLowN, tempWarningHighN, tempWarningN},
			{4'h0, sd, lo, hi, hi});
		chk({4'h0, flagLines}, {4'h0, sd, lo, hi, hi});
	endtask

	// 0 bridge tied, 1 parallel bridge, 2 single ended
	task automatic set_mode(input int m);
		bridgeTiedMode = (m == 0);
		parallelBridgeMode = (m == 1);
		singleEndedMode = (m == 2);
	endtask

	// cut a hang short
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			conclude();
		end
	end

	initial begin
		logic [3:0] grp;
		bad_count = 0;
		checks_done = 0;
		cycles = 0;
		rstn = 1'b0;
		set_mode(0);
		overtempError = 1'b0;
		tempAbove100 = 1'b0;
		tempAbove125 = 1'b0;
		overloadProtect = 4'h0;
		undervoltageProtect = 1'b0;
		gateDriveSupplyOk = 1'b1;
		commonSupplyOk = 1'b1;
		bootUndervoltage = 4'h0;
		repeat (6) @(negedge core_clk);
		rstn = 1'b1;
		settle();
		// device reset low: all off, pulldowns on, shutdown released
		chk({4'h0, hbHiZ}, 8'h0F);
		chk({4'h0, hbPulldown}, 8'h0F);
		flags(1'b1, 1'b1, 1'b1);
		set_mode(2);
		settle();
		chk({4'h0, hbPulldown}, 8'h00);
		set_mode(0);
		// power-up with each supply missing in turn
		gateDriveSupplyOk = 1'b0;
		u_ctrl.release_reset();
		settle();
		chk({4'h0, hbHiZ}, 8'h0F);
		chk({7'h00, shutdownFlagN}, 8'h00);
		gateDriveSupplyOk = 1'b1;
		commonSupplyOk = 1'b0;
		settle();
		chk({4'h0, hbHiZ}, 8'h0F);
		commonSupplyOk = 1'b1;
		settle();
		chk({4'h0, hbHiZ | hbPulldown}, 8'h00);
		flags(1'b1, 1'b1, 1'b1);
		// warning levels leave shutdown released
		tempAbove100 = 1'b1;
		settle();
		flags(1'b1, 1'b0, 1'b1);
		tempAbove125 = 1'b1;
		settle();
		flags(1'b1, 1'b0, 1'b0);
		tempAbove100 = 1'b0;
		tempAbove125 = 1'b0;
		settle();
		flags(1'b1, 1'b1, 1'b1);
		// supply undervoltage recovers by itself
		undervoltageProtect = 1'b1;
		settle();
		chk({4'h0, hbHiZ}, 8'h0F);
		flags(1'b0, 1'b1, 1'b1);
		chk({7'h00, resetReleaseOk}, 8'h00);
		undervoltageProtect = 1'b0;
		settle();
		chk({4'h0, hbHiZ}, 8'h00);
		flags(1'b1, 1'b1, 1'b1);
		// bootstrap undervoltage stays on its own half-bridge
		for (int i = 0; i < 4; i++) begin
			bootUndervoltage = 4'h1 << i;
			settle();
			chk({4'h0, hbHiZ}, {4'h0, 4'h1 << i});
			chk({7'h00, shutdownFlagN}, 8'h01);
			bootUndervoltage = 4'h0;
			settle();
			chk({4'h0, hbHiZ}, 8'h00);
		end
		// overload per channel and mode, held until a reset edge
		for (int m = 0; m < 3; m++) begin
			for (int ch = 0; ch < 4; ch++) begin
				set_mode(m);
				grp = (ch < 2) ? psfr_pkg::GRP_AB : psfr_pkg::GRP_CD;
				grp = (m == 1) ? psfr_pkg::GRP_ALL : grp;
				overloadProtect = 4'h1 << ch;
				settle();
				chk({4'h0, hbHiZ}, {4'h0, grp});
				chk({7'h00, shutdownFlagN}, 8'h00);
				overloadProtect = 4'h0;
				settle();
				chk({4'h0, hbHiZ}, {4'h0, grp});
				u_ctrl.pulse_reset();
				settle();
				chk({4'h0, hbHiZ}, 8'h00);
				chk({7'h00, shutdownFlagN}, 8'h01);
			end
		end
		set_mode(0);
		// overtemperature error latches; reset low masks it
		overtempError = 1'b1;
		settle();
		chk({4'h0, hbHiZ}, 8'h0F);
		flags(1'b0, 1'b1, 1'b1);
		overtempError = 1'b0;
		settle();
		chk({7'h00, shutdownFlagN}, 8'h00);
		overtempError = 1'b1;
		u_ctrl.hold_reset();
		settle();
		chk({7'h00, shutdownFlagN}, 8'h01);
		chk({4'h0, hbHiZ}, 8'h0F);
		overtempError = 1'b0;
		settle();
		u_ctrl.release_reset();
		settle();
		chk({4'h0, hbHiZ}, 8'h00);
		flags(1'b1, 1'b1, 1'b1);
		conclude();
	end
endmodule
